// File: verilog/fls_consts.svh
// Bit positions, reset values and reserved-bit masks of the flash lock block
`ifndef FLS_CONSTS_SVH
`define FLS_CONSTS_SVH

// ****************************************
// Hardware security byte layout
// ****************************************
`define FLS_HSB_DSPD_BIT   3'd7
`define FLS_HSB_LJMP_BIT   3'd6
`define FLS_HSB_EXPANDED_RAM_ENABLE_BIT_BIT   3'd3
`define FLS_HSB_LB2_BIT    3'd2
`define FLS_HSB_LB1_BIT    3'd1
`define FLS_HSB_LB0_BIT    3'd0
`define FLS_HSB_RSVD_MASK  8'h30
`define FLS_HSB_DELIVERED  8'hB8
`define FLS_HSB_INACTIVE   8'hFF

// ****************************************
// Software protection byte layout
// ****************************************
`define FLS_SSB_LB1_BIT    3'd1
`define FLS_SSB_LB0_BIT    3'd0
`define FLS_SSB_RSVD_MASK  8'hFC
`define FLS_SSB_RESET      8'hFF

// ****************************************
// Other extra array defaults
// ****************************************
`define FLS_SBV_RESET      8'hFC
`define FLS_BSB_RESET      8'hFF
`define FLS_BYTE_ERASED    8'hFF

// ****************************************
// External access pin reset level
// ****************************************
`define FLS_EA_RESET       1'b1

`endif

// File: verilog/fls_pkg.sv
// Types for the flash lock block
package fls_pkg;

    // Requesting path
    typedef enum logic [1:0] {
        FLS_SRC_PAR = 2'h0,
        FLS_SRC_ISP = 2'h1,
        FLS_SRC_API = 2'h2
    } fls_src_t;

    // Operation
    typedef enum logic [1:0] {
        FLS_OP_READ  = 2'h0,
        FLS_OP_WRITE = 2'h1,
        FLS_OP_ERASE = 2'h2
    } fls_op_t;

    // Target of a command
    typedef enum logic [3:0] {
        FLS_SEL_CODE = 4'h0,
        FLS_SEL_HSB  = 4'h1,
        FLS_SEL_SSB  = 4'h2,
        FLS_SEL_BSB  = 4'h3,
        FLS_SEL_SBV  = 4'h4,
        FLS_SEL_MFR  = 4'h5,
        FLS_SEL_ID1  = 4'h6,
        FLS_SEL_ID2  = 4'h7,
        FLS_SEL_ID3  = 4'h8
    } fls_sel_t;

    // Decoded hardware security level, one-hot
    typedef enum logic [3:0] {
        FLS_HLVL_1 = 4'h1,
        FLS_HLVL_2 = 4'h2,
        FLS_HLVL_3 = 4'h4,
        FLS_HLVL_4 = 4'h8
    } fls_hlvl_t;

endpackage

// File: verilog/fls_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module fls_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and control
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic ce,
    // Data
    input  wire logic d,
    output logic      q
);

    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge mclk) begin
        if (reset) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            q    <= RST_VAL;
        end else if (ce) begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                q <= s3_r;
            end
        end
    end

endmodule

// File: verilog/fls_nvbyte.sv
// One byte of the nonvolatile configuration store
`timescale 1ns/100ps
module fls_nvbyte #(
    parameter logic [7:0] RST_VAL = 8'hFF,
    parameter logic [7:0] ERS_VAL = 8'hFF,
    parameter logic [7:0] KEEP1   = 8'h00
) (
    // Clock and control
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       ce,
    // Update
    input  wire logic       load,
    input  wire logic       erase,
    input  wire logic [7:0] wdata,
    output logic      [7:0] q
);

    // Erase wins over a load in the same cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            q <= RST_VAL;
        end else if (ce) begin
            if (erase) begin
                q <= ERS_VAL;
            end else if (load) begin
                q <= wdata | KEEP1;
            end
        end
    end

endmodule

// File: verilog/fls_top.sv
// Flash lock and security logic: lock decode, access gating, config bytes
`timescale 1ns/100ps
`include "fls_consts.svh"
module fls_top
    import fls_pkg::*;
#(
    parameter logic [7:0] MFR_CODE = 8'h3C,
    parameter logic [7:0] ID1_CODE = 8'h41,
    parameter logic [7:0] ID2_CODE = 8'h42,
    parameter logic [7:0] ID3_CODE = 8'h43
) (
    // Clock, reset, enable
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       ce,
    // External access pin
    input  wire logic       external_access_pin,
    // Command port
    input  wire logic       cmd_valid,
    input  wire logic [1:0] cmd_src,
    input  wire logic [1:0] cmd_op,
    input  wire logic [3:0] cmd_sel,
    input  wire logic [7:0] cmd_wdata,
    // Command answer
    output logic            rsp_valid_r,
    output logic            rsp_refused_r,
    output logic      [7:0] rsp_data_r,
    // Flash array strobes
    output logic            flash_read_r,
    output logic            flash_write_r,
    output logic            flash_erase_r,
    // Access gates
    output logic            table_read_block_r,
    output logic            ext_exec_block_r,
    output logic            par_prog_block_r,
    output logic            par_verify_block_r,
    output logic            isp_prog_block_r,
    output logic            isp_verify_block_r,
    output logic            fetch_internal_r,
    output logic      [3:0] hw_level_r,
    // Configuration bits
    output logic            double_speed_bit_r,
    output logic            loader_jump_bit_r,
    output logic            expanded_ram_enable_bit_r,
    output logic      [7:0] boot_status_byte_r,
    output logic      [7:0] software_boot_vector_r
);

    // ****************************************
    // Stored bytes and pin
    // ****************************************
    logic [7:0] hardware_security_byte;
    logic [7:0] software_protection_byte;
    logic [7:0] bsb_q;
    logic [7:0] sbv_q;
    logic       ea_sync;
    logic       ea_latched_r;

    // ****************************************
    // Command decode
    // ****************************************
    wire        go        = cmd_valid & ce;
    wire        src_par   = (cmd_src == FLS_SRC_PAR);
    wire        src_isp   = (cmd_src == FLS_SRC_ISP);
    wire        op_rd     = (cmd_op == FLS_OP_READ);
    wire        op_wr     = (cmd_op == FLS_OP_WRITE);
    wire        op_er     = (cmd_op == FLS_OP_ERASE);
    wire        sel_code  = (cmd_sel == FLS_SEL_CODE);
    wire        sel_hsb   = (cmd_sel == FLS_SEL_HSB);
    wire        sel_ssb   = (cmd_sel == FLS_SEL_SSB);
    wire        sel_bsb   = (cmd_sel == FLS_SEL_BSB);
    wire        sel_sbv   = (cmd_sel == FLS_SEL_SBV);
    wire        sel_id    = (cmd_sel == FLS_SEL_MFR) |
                            (cmd_sel == FLS_SEL_ID1) |
                            (cmd_sel == FLS_SEL_ID2) |
                            (cmd_sel == FLS_SEL_ID3);

    // ****************************************
    // Hardware level decode
    // ****************************************
    // lock bits active low
    wire        hlb0_prog = ~hardware_security_byte[`FLS_HSB_LB0_BIT];
    wire        hlb1_prog = ~hardware_security_byte[`FLS_HSB_LB1_BIT];
    wire        hlb2_prog = ~hardware_security_byte[`FLS_HSB_LB2_BIT];

    fls_hlvl_t  hlvl;
    always_comb begin
        case ({hlb2_prog, hlb1_prog, hlb0_prog})
            3'b000:  hlvl = FLS_HLVL_1;
            3'b001:  hlvl = FLS_HLVL_2;
            3'b010,
            3'b011:  hlvl = FLS_HLVL_3;
            default: hlvl = FLS_HLVL_4;
        endcase
    end

    wire        lvl_ge2   = (hlvl != FLS_HLVL_1);
    wire        lvl_ge3   = (hlvl == FLS_HLVL_3) | (hlvl == FLS_HLVL_4);
    wire        lvl_4     = (hlvl == FLS_HLVL_4);

    // ****************************************
    // Software level decode
    // ****************************************
    // bit zero blocks programming
    wire        slb0_low  = ~software_protection_byte[`FLS_SSB_LB0_BIT];
    // bit one blocks program and verify
    wire        slb1_low  = ~software_protection_byte[`FLS_SSB_LB1_BIT];
    wire        isp_pblk  = slb0_low | slb1_low;
    wire        isp_vblk  = slb1_low;

    // ****************************************
    // Access permission
    // ****************************************
    // parallel gated by hardware, ISP by software
    wire        code_wr_ok = src_par ? ~lvl_ge2 :
                             src_isp ? ~isp_pblk : 1'b1;
    wire        code_rd_ok = src_par ? ~lvl_ge3 :
                             src_isp ? ~isp_vblk : 1'b1;
    // hardware byte reachable by programmer only
    wire        hsb_ok    = src_par & (op_rd | op_wr);
    // software bytes reachable on all paths, except boot byte writes from ISP while ISP programming is blocked
    wire        ssb_ok    = op_rd | op_wr;
    wire        boot_ok   = op_rd | (op_wr & ~(src_isp & isp_pblk));
    wire        id_ok     = op_rd;
    // chip erase from programmer or ISP
    wire        erase_ok  = op_er & sel_code & (cmd_src != FLS_SRC_API);

    wire        code_ok   = sel_code & ((op_rd & code_rd_ok) |
                                        (op_wr & code_wr_ok) | erase_ok);
    wire        allowed   = code_ok | (sel_hsb & hsb_ok) |
                            (sel_ssb & ssb_ok) |
                            ((sel_bsb | sel_sbv) & boot_ok) |
                            (sel_id & id_ok);

    // ****************************************
    // Update strobes
    // ****************************************
    wire        do_erase  = go & erase_ok;
    wire        par_erase = do_erase & src_par;
    wire        hsb_load  = go & sel_hsb & hsb_ok & op_wr;
    wire        ssb_load  = go & sel_ssb & op_wr;
    wire        bsb_load  = go & sel_bsb & op_wr & boot_ok;
    wire        sbv_load  = go & sel_sbv & op_wr & boot_ok;

    // Writes only program bits, so protection only rises
    wire [7:0]  hsb_wdata = hardware_security_byte & cmd_wdata;
    wire [7:0]  ssb_wdata = software_protection_byte & cmd_wdata;

    // ****************************************
    // Read data selection
    // ****************************************
    logic [7:0] rd_data;
    always_comb begin
        case (cmd_sel)
            FLS_SEL_HSB: rd_data = hardware_security_byte;
            FLS_SEL_SSB: rd_data = software_protection_byte;
            FLS_SEL_BSB: rd_data = bsb_q;
            FLS_SEL_SBV: rd_data = sbv_q;
            FLS_SEL_MFR: rd_data = MFR_CODE;
            FLS_SEL_ID1: rd_data = ID1_CODE;
            FLS_SEL_ID2: rd_data = ID2_CODE;
            FLS_SEL_ID3: rd_data = ID3_CODE;
            default:     rd_data = 8'h00;
        endcase
    end

    // ****************************************
    // Stored bytes
    // ****************************************
    // delivered hardware byte
    fls_nvbyte #(
        .RST_VAL (`FLS_HSB_DELIVERED),
        .ERS_VAL (`FLS_HSB_INACTIVE),
        .KEEP1   (`FLS_HSB_RSVD_MASK)
    ) u_hsb (
        .mclk  (mclk),
        .reset (reset),
        .ce    (ce),
        .load  (hsb_load),
        .erase (par_erase),
        .wdata (hsb_wdata),
        .q     (hardware_security_byte)
    );

    fls_nvbyte #(
        .RST_VAL (`FLS_SSB_RESET),
        .ERS_VAL (`FLS_SSB_RESET),
        .KEEP1   (`FLS_SSB_RSVD_MASK)
    ) u_ssb (
        .mclk  (mclk),
        .reset (reset),
        .ce    (ce),
        .load  (ssb_load),
        .erase (do_erase),
        .wdata (ssb_wdata),
        .q     (software_protection_byte)
    );

    fls_nvbyte #(
        .RST_VAL (`FLS_BSB_RESET),
        .ERS_VAL (`FLS_BSB_RESET),
        .KEEP1   (8'h00)
    ) u_bsb (
        .mclk  (mclk),
        .reset (reset),
        .ce    (ce),
        .load  (bsb_load),
        .erase (1'b0),
        .wdata (cmd_wdata),
        .q     (bsb_q)
    );

    fls_nvbyte #(
        .RST_VAL (`FLS_SBV_RESET),
        .ERS_VAL (`FLS_SBV_RESET),
        .KEEP1   (8'h00)
    ) u_sbv (
        .mclk  (mclk),
        .reset (reset),
        .ce    (ce),
        .load  (sbv_load),
        .erase (1'b0),
        .wdata (cmd_wdata),
        .q     (sbv_q)
    );

    // ****************************************
    // External access pin
    // ****************************************
    fls_sync #(
        .RST_VAL (`FLS_EA_RESET)
    ) u_ea_sync (
        .mclk  (mclk),
        .reset (reset),
        .ce    (ce),
        .d     (external_access_pin),
        .q     (ea_sync)
    );

    always_ff @(posedge mclk) begin
        if (reset) begin
            ea_latched_r <= ea_sync;
        end
    end

    wire        ea_eff    = lvl_ge2 ? ea_latched_r : ea_sync;

    // ****************************************
    // Command answer and flash strobes
    // ****************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            rsp_valid_r   <= 1'b0;
            rsp_refused_r <= 1'b0;
            rsp_data_r    <= 8'h00;
            flash_read_r  <= 1'b0;
            flash_write_r <= 1'b0;
            flash_erase_r <= 1'b0;
        end else if (ce) begin
            rsp_valid_r   <= cmd_valid;
            rsp_refused_r <= cmd_valid & ~allowed;
            rsp_data_r    <= (cmd_valid & allowed & op_rd) ? rd_data : 8'h00;
            flash_read_r  <= go & code_ok & op_rd;
            flash_write_r <= go & code_ok & op_wr;
            flash_erase_r <= do_erase;
        end
    end

    // ****************************************
    // Registered gates and configuration
    // ****************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            table_read_block_r        <= 1'b1;
            ext_exec_block_r          <= 1'b1;
            par_prog_block_r          <= 1'b1;
            par_verify_block_r        <= 1'b1;
            isp_prog_block_r          <= 1'b0;
            isp_verify_block_r        <= 1'b0;
            fetch_internal_r          <= `FLS_EA_RESET;
            hw_level_r                <= FLS_HLVL_4;
            double_speed_bit_r        <= 1'b1;
            loader_jump_bit_r         <= 1'b0;
            expanded_ram_enable_bit_r <= 1'b1;
            boot_status_byte_r        <= `FLS_BSB_RESET;
            software_boot_vector_r    <= `FLS_SBV_RESET;
        end else if (ce) begin
            table_read_block_r        <= lvl_ge2;
            par_prog_block_r          <= lvl_ge2;
            par_verify_block_r        <= lvl_ge3;
            ext_exec_block_r          <= lvl_4;
            isp_prog_block_r          <= isp_pblk;
            isp_verify_block_r        <= isp_vblk;
            fetch_internal_r          <= ea_eff;
            hw_level_r                <= hlvl;
            double_speed_bit_r        <=
                hardware_security_byte[`FLS_HSB_DSPD_BIT];
            loader_jump_bit_r         <=
                hardware_security_byte[`FLS_HSB_LJMP_BIT];
            expanded_ram_enable_bit_r <=
                hardware_security_byte[`FLS_HSB_EXPANDED_RAM_ENABLE_BIT_BIT];
            boot_status_byte_r        <= bsb_q;
            software_boot_vector_r    <= sbv_q;
        end
    end

endmodule

// File: test/fls_top_checker.sv
// Property checker for the flash lock block
`timescale 1ns/100ps
module fls_top_checker (
    // Clock and enable
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic       ce,
    // Command port
    input wire logic       cmd_valid,
    input wire logic [1:0] cmd_src,
    input wire logic [1:0] cmd_op,
    input wire logic [3:0] cmd_sel,
    // Answer and gates
    input wire logic       rsp_valid_r,
    input wire logic       rsp_refused_r,
    input wire logic       flash_write_r,
    input wire logic       flash_erase_r,
    input wire logic       table_read_block_r,
    input wire logic       par_verify_block_r,
    input wire logic       ext_exec_block_r,
    input wire logic       isp_prog_block_r,
    input wire logic       isp_verify_block_r,
    input wire logic [3:0] hw_level_r
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    wire logic take = ce && cmd_valid;

    rsp_follows_a: assert property (take |=> rsp_valid_r)
        else $error("command got no answer");
    rsp_idle_a: assert property (ce && !cmd_valid |=> !rsp_valid_r)
        else $error("answer without command");
    refuse_quiet_a: assert property (rsp_refused_r |->
        !flash_write_r && !flash_erase_r)
        else $error("strobe on refused command");
    level_gate_a: assert property ($onehot(hw_level_r) &&
        table_read_block_r == !hw_level_r[0] &&
        par_verify_block_r == (hw_level_r[2] | hw_level_r[3]) &&
        ext_exec_block_r == hw_level_r[3])
        else $error("gates disagree with level");
    isp_nest_a: assert property (isp_verify_block_r |-> isp_prog_block_r)
        else $error("verify blocked without program block");
    id_read_a: assert property (take && cmd_op == 2'h0 &&
        cmd_sel inside {[4'h5:4'h8]} |=> !rsp_refused_r)
        else $error("identity read refused");
    erase_open_a: assert property (take && cmd_src == 2'h0 &&
        cmd_op == 2'h2 && cmd_sel == 4'h0 ##1 ce
        |=> hw_level_r == 4'h1 && !table_read_block_r)
        else $error("erase left locks active");
    hsb_guard_a: assert property (take && cmd_src != 2'h0 &&
        cmd_sel == 4'h1 && cmd_op == 2'h1 |=> rsp_refused_r)
        else $error("hardware byte written by software");
    par_verify_a: assert property (take && cmd_src == 2'h0 &&
        cmd_op == 2'h0 && cmd_sel == 4'h0 && par_verify_block_r &&
        $past(cmd_op) != 2'h2 |=> rsp_refused_r)
        else $error("parallel verify not refused");
    isp_write_a: assert property (take && cmd_src == 2'h1 &&
        cmd_op == 2'h1 && cmd_sel == 4'h0 && isp_prog_block_r &&
        $past(cmd_op) != 2'h2 |=> rsp_refused_r)
        else $error("isp program not refused");
endmodule

bind fls_top fls_top_checker i_chk (
    .mclk, .reset, .ce, .cmd_valid, .cmd_src, .cmd_op, .cmd_sel,
    .rsp_valid_r, .rsp_refused_r, .flash_write_r, .flash_erase_r,
    .table_read_block_r, .par_verify_block_r, .ext_exec_block_r,
    .isp_prog_block_r, .isp_verify_block_r, .hw_level_r
);

// File: test/fls_host_model.sv
// Programmer or loader host that issues commands
`timescale 1ns/100ps
module fls_host_model (
    // Clock
    input  wire logic       mclk,
    // Command port
    output logic            cmd_valid,
    output logic      [1:0] cmd_src,
    output logic      [1:0] cmd_op,
    output logic      [3:0] cmd_sel,
    output logic      [7:0] cmd_wdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_src = 2'h0;
        cmd_op = 2'h0;
        cmd_sel = 4'h0;
        cmd_wdata = 8'h00;
    end

    // One command taken at the next edge
    task automatic issue(input logic [1:0] s, input logic [1:0] o,
                         input logic [3:0] l, input logic [7:0] wd);
        logic [7:0] d;
        d = wd;
        if (l == 4'h2 && o == 2'h1) begin
            d = d | 8'hFC;
        end
        cmd_valid <= 1'b1;
        cmd_src <= s;
        cmd_op <= o;
        cmd_sel <= l;
        cmd_wdata <= d;
        @(posedge mclk);
    endtask

    // Released select and data lines do not keep old values
    task automatic idle();
        cmd_valid <= 1'b0;
        cmd_sel <= ~cmd_sel;
        cmd_wdata <= ~cmd_wdata;
        @(posedge mclk);
    endtask
endmodule

// File: test/fls_top_tb.sv
// Self-checking testbench for the flash lock block
`timescale 1ns/100ps
module fls_top_tb;
    // Identity codes: arbitrary values
    localparam logic [7:0] IDS [4] = '{8'h3C, 8'h41, 8'h42, 8'h43};
    logic       mclk, reset, ce, external_access_pin, ce_d;
    logic       cmd_valid;
    logic [1:0] cmd_src, cmd_op;
    logic [3:0] cmd_sel, hw_level_r;
    logic [7:0] cmd_wdata, rsp_data_r, w;
    logic [7:0] boot_status_byte_r, software_boot_vector_r;
    logic       rsp_valid_r, rsp_refused_r, flash_read_r, flash_write_r;
    logic       flash_erase_r, table_read_block_r, ext_exec_block_r;
    logic       par_prog_block_r, par_verify_block_r, isp_prog_block_r;
    logic       isp_verify_block_r, fetch_internal_r, double_speed_bit_r;
    logic       loader_jump_bit_r, expanded_ram_enable_bit_r;
    logic [12:0] exp_q [$];
    logic [12:0] e_m;
    integer     failures, checked, seed;

    fls_top #(.MFR_CODE(IDS[0]), .ID1_CODE(IDS[1]), .ID2_CODE(IDS[2]),
              .ID3_CODE(IDS[3])) i_dut (
        .mclk, .reset, .ce, .external_access_pin, .cmd_valid, .cmd_src,
        .cmd_op, .cmd_sel, .cmd_wdata, .rsp_valid_r, .rsp_refused_r,
        .rsp_data_r, .flash_read_r, .flash_write_r, .flash_erase_r,
        .table_read_block_r, .ext_exec_block_r, .par_prog_block_r,
        .par_verify_block_r, .isp_prog_block_r, .isp_verify_block_r,
        .fetch_internal_r, .hw_level_r, .double_speed_bit_r,
        .loader_jump_bit_r, .expanded_ram_enable_bit_r,
        .boot_status_byte_r, .software_boot_vector_r);
    fls_host_model i_host (
        .mclk, .cmd_valid, .cmd_src, .cmd_op, .cmd_sel, .cmd_wdata);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input string n, input logic [7:0] s,
                         input logic [7:0] x);
        checked = checked + 1;
        if (s !== x) begin
            failures = failures + 1;
            $display("BAD %s expected %h seen %h", n, x, s);
        end
    endtask

    task automatic chk1(input string n, input logic s, input logic x);
        check(n, {7'h0, s}, {7'h0, x});
    endtask

    task automatic end_sim();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Expected answer: {strobes, check data, refused, data}
    task automatic cmd(input logic [1:0] s, input logic [1:0] o,
                       input logic [3:0] l, input logic [7:0] d,
                       input logic [9:0] e);
        exp_q.push_back({(l == 4'h0 && !e[8]) ? 3'(4 >> o) : 3'h0, e});
        i_host.issue(s, o, l, d);
    endtask

    task automatic gates(input logic [3:0] lvl);
        check("level", {4'h0, hw_level_r}, {4'h0, lvl});
        chk1("table", table_read_block_r, lvl != 4'h1);
        chk1("parprog", par_prog_block_r, lvl != 4'h1);
        chk1("verify", par_verify_block_r, lvl[2] | lvl[3]);
        chk1("extexec", ext_exec_block_r, lvl[3]);
    endtask

    // Answers are compared in order of issue
    always @(posedge mclk) begin
        if (rsp_valid_r === 1'b1 && ce_d === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("spare", 8'h01, 8'h00);
            end else begin
                e_m = exp_q.pop_front();
                chk1("refused", rsp_refused_r, e_m[8]);
                check("strobe", {5'h0, flash_read_r, flash_write_r,
                      flash_erase_r}, {5'h0, e_m[12:10]});
                if (e_m[9]) begin
                    check("data", rsp_data_r, e_m[7:0]);
                end
            end
        end
        ce_d = ce;
    end

    initial begin
        #100000;
        failures = failures + 1;
        end_sim();
    end

    initial begin
        seed = 75089;
        failures = 0;
        checked = 0;
        ce_d = 1'b0;
        reset = 1'b1;
        ce = 1'b1;
        external_access_pin = 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        gates(4'h8);
        chk1("dspd", double_speed_bit_r, 1'b1);
        chk1("ljmp", loader_jump_bit_r, 1'b0);
        chk1("expanded_ram_enable_bit", expanded_ram_enable_bit_r, 1'b1);
        chk1("ispp", isp_prog_block_r, 1'b0);
        check("bsb", boot_status_byte_r, 8'hFF);
        check("sbv", software_boot_vector_r, 8'hFC);
        for (int i = 5; i <= 8; i++) begin
            for (int s = 0; s < 3; s++) begin
                cmd(2'(s), 2'h0, 4'(i), 8'h00, {2'h2, IDS[i-5]});
            end
        end
        cmd(2'h0, 2'h0, 4'h2, 8'h00, 10'h2FF);
        cmd(2'h2, 2'h0, 4'h2, 8'h00, 10'h2FF);
        cmd(2'h0, 2'h0, 4'h1, 8'h00, 10'h2B8);
        cmd(2'h1, 2'h1, 4'h0, 8'h5A, 10'h200);
        cmd(2'h1, 2'h1, 4'h1, 8'h00, 10'h300);
        cmd(2'h0, 2'h1, 4'hF, 8'h00, 10'h300);
        for (int v = 1; v <= 4; v++) begin
            // erase before a new load, read back after the lock
            cmd(2'h0, 2'h2, 4'h0, 8'h00, 10'h200);
            w = 8'($random(seed));
            case (v)
                1: w[2:0] = 3'h7;
                2: w[2:0] = 3'h6;
                3: w[2:1] = 2'h2;
                default: w[2] = 1'b0;
            endcase
            cmd(2'h0, 2'h1, 4'h1, w, 10'h200);
            cmd(2'h0, 2'h0, 4'h1, 8'h00, {2'h2, w | 8'h30});
            i_host.idle();
            ce <= 1'b0;
            repeat (3) @(posedge mclk);
            gates(4'(1 << (v - 1)));
            ce <= 1'b1;
            repeat (3) @(posedge mclk);
            gates(4'(1 << (v - 1)));
            chk1("dspd", double_speed_bit_r, w[7]);
            chk1("ljmp", loader_jump_bit_r, w[6]);
            chk1("expanded_ram_enable_bit", expanded_ram_enable_bit_r, w[3]);
            cmd(2'h0, 2'h0, 4'h0, 8'h00, v >= 3 ? 10'h300 : 10'h000);
            cmd(2'h0, 2'h1, 4'h0, w, v >= 2 ? 10'h300 : 10'h200);
            cmd(2'h0, 2'h0, 4'h5, 8'h00, {2'h2, IDS[0]});
            i_host.idle();
            external_access_pin <= 1'b0;
            repeat (8) @(posedge mclk);
            chk1("fetch", fetch_internal_r, v >= 2);
            external_access_pin <= 1'b1;
            repeat (8) @(posedge mclk);
        end
        cmd(2'h1, 2'h1, 4'h3, 8'h00, 10'h200);
        cmd(2'h1, 2'h1, 4'h2, 8'h02, 10'h200);
        cmd(2'h1, 2'h0, 4'h2, 8'h00, 10'h2FE);
        i_host.idle();
        repeat (2) @(posedge mclk);
        check("bsb", boot_status_byte_r, 8'h00);
        chk1("ispp", isp_prog_block_r, 1'b1);
        chk1("ispv", isp_verify_block_r, 1'b0);
        cmd(2'h1, 2'h1, 4'h0, 8'h11, 10'h300);
        cmd(2'h1, 2'h1, 4'h4, 8'h00, 10'h300);
        cmd(2'h1, 2'h0, 4'h0, 8'h00, 10'h000);
        cmd(2'h1, 2'h1, 4'h2, 8'h01, 10'h200);
        cmd(2'h0, 2'h0, 4'h2, 8'h00, 10'h2FC);
        i_host.idle();
        repeat (2) @(posedge mclk);
        chk1("ispv", isp_verify_block_r, 1'b1);
        cmd(2'h1, 2'h0, 4'h0, 8'h00, 10'h300);
        cmd(2'h1, 2'h2, 4'h0, 8'h00, 10'h200);
        i_host.idle();
        repeat (2) @(posedge mclk);
        chk1("ispp", isp_prog_block_r, 1'b0);
        repeat (4) @(posedge mclk);
        check("pending", 8'(exp_q.size()), 8'h00);
        end_sim();
    end
endmodule
